/* File: hdl/sfp_map.svh */
// constants for the stepper fault protection block
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
`define SFP_CLK_MHZ          250
`define SFP_OSC_DIV_NS       156
`define SFP_OSC_DIV_CYC      ((`SFP_OSC_DIV_NS * `SFP_CLK_MHZ) / 1000)
`define SFP_TSD_MASK_TICKS   32
`define SFP_ISD_MASK_TICKS   8
`define SFP_BLANK_NS         400
`define SFP_BLANK_CYC        ((`SFP_BLANK_NS * `SFP_CLK_MHZ) / 1000)
`define SFP_LEVEL_FULL       2'h3
`define SFP_LEVEL_HIGH       2'h2
`define SFP_LEVEL_LOW        2'h1
`define SFP_LEVEL_ZERO       2'h0
`endif

/* File: hdl/sfp_pkg.sv */
// types for the stepper fault protection block
package sfp_pkg;
  typedef logic [1:0] sfp_level_t;
  typedef enum logic [1:0] {
    SFP_RUN   = 2'b00,
    SFP_FAULT = 2'b01,
    SFP_STBY  = 2'b10
  } sfp_state_e;
endpackage

/* File: hdl/sfp_mask_if.sv */
// interface carrying one fault detector's request and result
`timescale 1ns/1ps
interface sfp_mask_if;
  logic raw;
  logic tick;
  logic hold;
  logic trip;
  modport ctrl (output raw, output tick, output hold, input trip);
  modport filt (input raw, input tick, input hold, output trip);
endinterface

/* File: hdl/sfp_mask_filter.sv */
// persistence filter counting fast oscillator ticks
`timescale 1ns/1ps
module sfp_mask_filter #(
  parameter int TICKS = 8
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  sfp_mask_if.filt  port
);
  logic [5:0] count;

  // condition must persist for TICKS oscillator cycles before tripping
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || port.hold || !port.raw) begin
      count <= 6'h00;
    end else if (port.tick && count != 6'(TICKS)) begin
      count <= count + 6'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || port.hold) begin
      port.trip <= 1'b0;
    end else begin
      port.trip <= port.raw && port.tick && (count == 6'(TICKS - 1));
    end
  end
endmodule

/* File: hdl/sfp_top.sv */
// fault latch, output kill and current level select of the stepper driver
// How it works
// - over-temperature, once filtered, latches a fault and turns every output off
// - over-current, once filtered, latches a fault and turns every output off
// - fault stays latched until motor supply is lost or standby is entered
// - over-temperature must persist 32 fast oscillator cycles before latching
// - over-current must persist 8 fast oscillator cycles before latching
// - current-sense comparator changes ignored for 400 ns blanking after a switch
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_top (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic            motor_supply_ok_in,
  input  wire logic            standby_n_in,
  input  wire logic            over_temp_in,
  input  wire logic            over_current_in,
  input  wire logic            sense_trip_in,
  input  wire logic            switch_event_in,
  input  wire logic [1:0]      current_level_sel_a_in,
  input  wire logic [1:0]      current_level_sel_b_in,
  output logic                 outputs_enable_out,
  output logic                 thermal_shutdown_out,
  output logic                 overcurrent_shutdown_out,
  output logic                 error_n_out,
  output logic                 sense_trip_out,
  output sfp_pkg::sfp_level_t  level_a_out,
  output sfp_pkg::sfp_level_t  level_b_out
);
  import sfp_pkg::*;

  sfp_state_e state;
  sfp_state_e next_state;
  logic [7:0] osc_div;
  logic       osc_tick;
  logic [7:0] blank_count;
  logic       clear_req;
  logic [1:0] sel_pair [2];
  sfp_level_t next_level [2];
  sfp_mask_if tsd_if ();
  sfp_mask_if isd_if ();

  // fast internal oscillator modelled as a tick from the system clock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || osc_div == 8'(`SFP_OSC_DIV_CYC - 1)) begin
      osc_div <= 8'h00;
    end else begin
      osc_div <= osc_div + 8'h01;
    end
  end
  assign osc_tick = (osc_div == 8'(`SFP_OSC_DIV_CYC - 1));

  assign clear_req = !motor_supply_ok_in || !standby_n_in;

  assign tsd_if.raw  = over_temp_in;
  assign tsd_if.tick = osc_tick;
  assign tsd_if.hold = clear_req;
  assign isd_if.raw  = over_current_in;
  assign isd_if.tick = osc_tick;
  assign isd_if.hold = clear_req;

  sfp_mask_filter #(.TICKS(`SFP_TSD_MASK_TICKS)) u_tsd (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .port     (tsd_if.filt)
  );

  sfp_mask_filter #(.TICKS(`SFP_ISD_MASK_TICKS)) u_isd (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .port     (isd_if.filt)
  );

  // a trip in the same cycle as a lost clear condition still latches
  always_comb begin
    next_state = state;
    case (state)
      SFP_RUN: begin
        if (clear_req) begin
          next_state = SFP_STBY;
        end else if (tsd_if.trip || isd_if.trip) begin
          next_state = SFP_FAULT;
        end
      end
      SFP_FAULT: begin
        if (clear_req) begin
          next_state = SFP_STBY;
        end
      end
      SFP_STBY: begin
        if (!clear_req && (tsd_if.trip || isd_if.trip)) begin
          next_state = SFP_FAULT;
        end else if (!clear_req) begin
          next_state = SFP_RUN;
        end
      end
      default: next_state = SFP_STBY;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= SFP_STBY;
    end else begin
      state <= next_state;
    end
  end

  // each detector keeps its own flag, even once the other has shut down
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || clear_req) begin
      thermal_shutdown_out <= 1'b0;
    end else if (tsd_if.trip) begin
      thermal_shutdown_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || clear_req) begin
      overcurrent_shutdown_out <= 1'b0;
    end else if (isd_if.trip) begin
      overcurrent_shutdown_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      outputs_enable_out <= 1'b0;
    end else begin
      outputs_enable_out <= (next_state == SFP_RUN);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      error_n_out <= 1'b1;
    end else begin
      error_n_out <= (next_state != SFP_FAULT);
    end
  end

  // blanking hides switching spikes from the chopping comparator
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      blank_count <= 8'h00;
    end else if (switch_event_in) begin
      blank_count <= 8'(`SFP_BLANK_CYC);
    end else if (blank_count != 8'h00) begin
      blank_count <= blank_count - 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sense_trip_out <= 1'b0;
    end else begin
      sense_trip_out <= sense_trip_in && blank_count == 8'h00 && !switch_event_in;
    end
  end

  assign sel_pair[0] = current_level_sel_a_in;
  assign sel_pair[1] = current_level_sel_b_in;

  // same decode for both channels; bit 1 of a pair is the first select
  for (genvar ch = 0; ch < 2; ch++) begin : g_level
    always_comb begin
      case (sel_pair[ch])
        2'h3:    next_level[ch] = `SFP_LEVEL_FULL;
        2'h2:    next_level[ch] = `SFP_LEVEL_HIGH;
        2'h1:    next_level[ch] = `SFP_LEVEL_LOW;
        default: next_level[ch] = `SFP_LEVEL_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      level_a_out <= `SFP_LEVEL_ZERO;
      level_b_out <= `SFP_LEVEL_ZERO;
    end else begin
      level_a_out <= next_level[0];
      level_b_out <= next_level[1];
    end
  end
endmodule

/* File: testbench/sfp_properties.sv */
// assertions on the fault protection top ports
`timescale 1ns/1ps
module sfp_properties (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic motor_supply_ok_in,
  input wire logic standby_n_in,
  input wire logic over_temp_in,
  input wire logic over_current_in,
  input wire logic switch_event_in,
  input wire logic sense_trip_out,
  input wire logic outputs_enable_out,
  input wire logic thermal_shutdown_out,
  input wire logic error_n_out,
  input wire logic overcurrent_shutdown_out
);
  // raw high runs, restarted whenever a clear holds the filters
  logic [10:0] c_oc;
  logic [10:0] c_ot;
  wire logic   hold = rst_n_in && motor_supply_ok_in && standby_n_in;
  always_ff @(posedge clk_in) begin
    c_oc <= (hold && over_current_in) ? c_oc + 11'h1 : 11'h0;
  end
  always_ff @(posedge clk_in) begin
    c_ot <= (hold && over_temp_in) ? c_ot + 11'h1 : 11'h0;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  kill_temp_a: assert property (thermal_shutdown_out |-> !outputs_enable_out) else $error("on");
  kill_cur_a: assert property (overcurrent_shutdown_out |-> !outputs_enable_out) else $error("on");
  latch_hold_a: assert property ($fell(thermal_shutdown_out) || $fell(overcurrent_shutdown_out)
    |-> !$past(hold)) else $error("lost");
  temp_due_a: assert property (c_ot == 11'h4E6 |-> thermal_shutdown_out) else $error("late");
  cur_due_a: assert property (c_oc == 11'h13E |-> overcurrent_shutdown_out) else $error("late");
  cur_mask_a: assert property ($rose(overcurrent_shutdown_out) |-> $past(c_oc, 2) >= 11'h10E) else $error("early");
  sense_blank_a: assert property (switch_event_in |-> ##2 !sense_trip_out [*8]) else $error("unblanked");
  temp_mask_a: assert property ($rose(thermal_shutdown_out) |-> $past(c_ot, 2) >= 11'h4B6) else $error("early");
  err_pin_a: assert property (!error_n_out |-> !outputs_enable_out &&
    (thermal_shutdown_out || overcurrent_shutdown_out)) else $error("error pin without fault");
endmodule
bind sfp_top sfp_properties sfp_properties_i (.*);

/* File: testbench/sfp_ctrl_model.sv */
// motor controller model driving supply and standby
`timescale 1ns/1ps
module sfp_ctrl_model (
  input  wire logic clk_in,
  output logic      motor_supply_ok_out = 1'h1,
  output logic      standby_n_out = 1'h1
);
  // a latched fault only leaves through a supply cycle or standby
  task automatic resume(input bit by_supply);
    @(posedge clk_in);
    if (by_supply) motor_supply_ok_out <= 1'h0;
    else standby_n_out <= 1'h0;
    repeat (4) @(posedge clk_in);
    motor_supply_ok_out <= 1'h1;
    standby_n_out <= 1'h1;
  endtask
endmodule

/* File: testbench/sfp_top_tb.sv */
// self-checking bench for the fault protection block
`timescale 1ns/1ps
`include "sfp_map.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %h %h", $time, a, b); end end
module sfp_top_tb;
  import sfp_pkg::*;
  logic       clk_in = 0, rst_n_in = 0, ot = 0, oc = 0, st = 0, sw = 0;
  logic [1:0] sa = 0, sb = 0;
  logic       ok, sn, en, thermal_shutdown, overcurrent_shutdown, sense, er;
  sfp_level_t la, lb;
  integer     n_mismatch = 0, compares = 0, seed = 32'hfd1a, i;
  always #2 clk_in = ~clk_in;
  sfp_ctrl_model sfp_ctrl_model_i (.clk_in(clk_in), .motor_supply_ok_out(ok), .standby_n_out(sn));
  sfp_top sfp_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .motor_supply_ok_in(ok), .standby_n_in(sn),
    .over_temp_in(ot), .over_current_in(oc), .sense_trip_in(st), .switch_event_in(sw),
    .current_level_sel_a_in(sa), .current_level_sel_b_in(sb), .outputs_enable_out(en),
    .thermal_shutdown_out(thermal_shutdown), .overcurrent_shutdown_out(overcurrent_shutdown), .error_n_out(er), .sense_trip_out(sense),
    .level_a_out(la), .level_b_out(lb));
  // level code expected for a select pair, bit 1 is the first select
  function automatic sfp_level_t level_of(input logic [1:0] sel);
    case (sel)
      2'h3:    return `SFP_LEVEL_FULL;
      2'h2:    return `SFP_LEVEL_HIGH;
      2'h1:    return `SFP_LEVEL_LOW;
      default: return `SFP_LEVEL_ZERO;
    endcase
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // hold one comparator high n cycles; latch expected past mask ticks times tick period
  task automatic raw(input bit hot, input int n);
    int e;
    e = n >= (hot ? `SFP_TSD_MASK_TICKS : `SFP_ISD_MASK_TICKS) * `SFP_OSC_DIV_CYC;
    @(posedge clk_in);
    if (hot) ot <= 1'h1;
    else oc <= 1'h1;
    wt(n - 1);
    @(posedge clk_in);
    {ot, oc} <= 2'h0;
    wt(3);
    `CHK(hot ? thermal_shutdown : overcurrent_shutdown, e[0])
    `CHK(en, ~e[0])
    `CHK(er, ~e[0])
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_in);
      sa <= i[1:0];
      sb <= 2'($random(seed));
      wt(2);
      `CHK(la, level_of(sa))
      `CHK(lb, level_of(sb))
    end
    $display("levels done");
    raw(0, 250);
    raw(0, 330);
    wt(20);
    `CHK(overcurrent_shutdown, 1'h1)
    sfp_ctrl_model_i.resume(0);
    wt(4);
    `CHK({overcurrent_shutdown, en, er}, 3'h3)
    $display("overcurrent done");
    raw(1, 1200);
    raw(1, 1260);
    sfp_ctrl_model_i.resume(1);
    wt(4);
    `CHK({thermal_shutdown, en, er}, 3'h3)
    $display("thermal done");
    @(posedge clk_in);
    {st, sw} <= 2'h3;
    @(posedge clk_in);
    sw <= 1'h0;
    wt(3);
    `CHK(sense, 1'h0)
    wt(58);
    `CHK(sense, 1'h0)
    wt(76);
    `CHK(sense, 1'h1)
    $display("blanking done");
    close_out;
  end
endmodule
